// ---- csc_clock_synth_unit.sv ----
// Purpose: clock synthesis control with AXI4-Lite register access
// Assumes: source clocks arrive as one-cycle ticks on clk_sys_i
// Notes:   double_rate_sys_clock_o is a tick train, one pulse per output period
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module csc_clock_synth_unit #(
	parameter int PD_DELAY = csc_pkg::PD_DELAY
) (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	// axi4-lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	// axi4-lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	// axi4-lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// clock sources
	input  wire logic        relax_osc_tick_i,
	input  wire logic        ext_ref_tick_i,
	input  wire logic        pll_out_tick_i,
	// chip state and analog status
	input  wire logic        stop_mode_i,
	input  wire logic        lock0_flag_i,
	input  wire logic        lock1_flag_i,
	input  wire logic        ref_lost_i,
	// analog controls
	output logic             pll_power_down_o,
	output logic             lock_detector_en_o,
	output logic [15:0]      osc_control_o,
	// interrupts
	output logic             lock0_irq_o,
	output logic             lock1_irq_o,
	output logic             ref_loss_irq_o,
	// clock to the system integration unit
	output logic             double_rate_sys_clock_o,
	output logic [1:0]       sysclk_src_state_o
);
	csc_pkg::csc_ctrl_type  ctrl_reg;
	csc_pkg::csc_ctrl_type  ctrl_next;
	csc_pkg::csc_divby_type divby_reg;
	logic [15:0]            osc_ctrl_reg;
	logic [15:0]            check_ref_reg;
	logic [15:0]            check_target_reg;
	logic [15:0]            write_prot_reg;
	logic [PD_DELAY-1:0]    pd_pipe_reg;
	logic                   wr_fire;
	logic                   rd_fire;
	logic [2:0]             wr_idx;
	logic [2:0]             rd_idx;
	logic                   wr_hit;
	logic                   rd_hit;
	logic [15:0]            wr_data;
	logic [15:0]            wr_mask;
	logic [15:0]            rd_word;
	logic [15:0]            status_word;
	logic                   force_master;
	logic                   prescaler_tick;
	logic                   source_tick;
	logic [1:0]             src_state;

	initial begin
		if (PD_DELAY < 2) $error("power-down delay must be at least two cycles");
	end

	// --------------------------------------------------------------
	// bus handshake
	// --------------------------------------------------------------
	// address and data are taken together; holding one until the other
	// arrives keeps the write path single-state at no cost to the master
	assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready  = wr_fire;
	assign rd_fire       = s_axi_arvalid & ~s_axi_rvalid;
	assign s_axi_arready = rd_fire;

	assign wr_idx  = s_axi_awaddr[csc_pkg::IDX_LSB +: 3];
	assign rd_idx  = s_axi_araddr[csc_pkg::IDX_LSB +: 3];
	assign wr_hit  = (s_axi_awaddr[31:csc_pkg::ADDR_W] == '0)
	              && (s_axi_awaddr[1:0] == 2'h0)
	              && (wr_idx != csc_pkg::IDX_RESERVED);
	assign rd_hit  = (s_axi_araddr[31:csc_pkg::ADDR_W] == '0)
	              && (s_axi_araddr[1:0] == 2'h0)
	              && (rd_idx != csc_pkg::IDX_RESERVED);
	assign wr_data = s_axi_wdata[15:0];
	assign wr_mask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= csc_pkg::AXI_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? csc_pkg::AXI_OKAY : csc_pkg::AXI_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= csc_pkg::AXI_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {16'h0000, rd_word};
			s_axi_rresp  <= rd_hit ? csc_pkg::AXI_OKAY : csc_pkg::AXI_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// read mux
	// --------------------------------------------------------------
	always_comb begin
		if (!rd_hit) begin
			rd_word = 16'h0000;
		end else if (rd_idx == csc_pkg::IDX_PLL_CONTROL) begin
			rd_word = ctrl_reg;
		end else if (rd_idx == csc_pkg::IDX_DIVIDE_BY) begin
			rd_word = {divby_reg, 8'h00};
		end else if (rd_idx == csc_pkg::IDX_SYNTH_STATUS) begin
			rd_word = status_word;
		end else if (rd_idx == csc_pkg::IDX_OSC_CONTROL) begin
			rd_word = osc_ctrl_reg;
		end else if (rd_idx == csc_pkg::IDX_CHECK_REF) begin
			rd_word = check_ref_reg;
		end else if (rd_idx == csc_pkg::IDX_CHECK_TARGET) begin
			rd_word = check_target_reg;
		end else begin
			rd_word = write_prot_reg;
		end
	end

	always_comb begin
		status_word                      = 16'h0000;
		status_word[csc_pkg::ST_LOCK1]   = lock1_flag_i;
		status_word[csc_pkg::ST_LOCK0]   = lock0_flag_i;
		status_word[csc_pkg::ST_PLLOFF]  = pll_power_down_o;
		status_word[csc_pkg::ST_LOSS]    = ref_lost_i;
		status_word[1:0]                 = src_state;
	end

	// --------------------------------------------------------------
	// control register
	// --------------------------------------------------------------
	assign force_master = stop_mode_i | ctrl_reg.pll_power_down;

	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_fire && wr_hit && wr_idx == csc_pkg::IDX_PLL_CONTROL) begin
			// reserved bits are masked off, so they stay zero
			ctrl_next = (ctrl_reg & ~(wr_mask & csc_pkg::CTRL_WMASK))
			          | (wr_data & wr_mask & csc_pkg::CTRL_WMASK);
			// reserved source codes leave the field unchanged
			if (!wr_mask[0] || (wr_data[1:0] != csc_pkg::SRC_MASTER
			    && wr_data[1:0] != csc_pkg::SRC_PLL)) begin
				ctrl_next.sysclk_src_sel = ctrl_reg.sysclk_src_sel;
			end
		end
		if (stop_mode_i || ctrl_next.pll_power_down) begin
			ctrl_next.sysclk_src_sel = csc_pkg::SRC_MASTER;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_reg <= csc_pkg::CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// --------------------------------------------------------------
	// other registers
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			divby_reg <= csc_pkg::DIVBY_RESET[15:8];
		end else if (wr_fire && wr_hit && wr_idx == csc_pkg::IDX_DIVIDE_BY && wr_mask[8]) begin
			divby_reg <= wr_data[15:8];
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			osc_ctrl_reg     <= csc_pkg::OTHER_RESET;
			check_ref_reg    <= csc_pkg::OTHER_RESET;
			check_target_reg <= csc_pkg::OTHER_RESET;
			write_prot_reg   <= csc_pkg::OTHER_RESET;
		end else if (wr_fire && wr_hit) begin
			if (wr_idx == csc_pkg::IDX_OSC_CONTROL) begin
				osc_ctrl_reg <= (osc_ctrl_reg & ~wr_mask) | (wr_data & wr_mask);
			end else if (wr_idx == csc_pkg::IDX_CHECK_REF) begin
				check_ref_reg <= (check_ref_reg & ~wr_mask) | (wr_data & wr_mask);
			end else if (wr_idx == csc_pkg::IDX_CHECK_TARGET) begin
				check_target_reg <= (check_target_reg & ~wr_mask) | (wr_data & wr_mask);
			end else if (wr_idx == csc_pkg::IDX_WRITE_PROT) begin
				write_prot_reg <= (write_prot_reg & ~wr_mask) | (wr_data & wr_mask);
			end
		end
	end

	assign osc_control_o = osc_ctrl_reg;

	// --------------------------------------------------------------
	// pll power-down delay
	// --------------------------------------------------------------
	// the pll sees the bit four cycles late; the source select is forced
	// at once, so the core leaves the pll before the pll stops
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pd_pipe_reg <= {PD_DELAY{1'b1}};
		end else begin
			pd_pipe_reg <= {pd_pipe_reg[PD_DELAY-2:0], ctrl_reg.pll_power_down};
		end
	end

	assign pll_power_down_o   = pd_pipe_reg[PD_DELAY-1];
	assign lock_detector_en_o = ctrl_reg.lock_detector_en;

	// --------------------------------------------------------------
	// interrupts
	// --------------------------------------------------------------
	csc_edge_detect u_lock0_edge (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.flag_i    (lock0_flag_i),
		.mode_i    (ctrl_reg.lock0_irq_edge_sel),
		.irq_o     (lock0_irq_o)
	);

	csc_edge_detect u_lock1_edge (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.flag_i    (lock1_flag_i),
		.mode_i    (ctrl_reg.lock1_irq_edge_sel),
		.irq_o     (lock1_irq_o)
	);

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ref_loss_irq_o <= 1'b0;
		end else begin
			ref_loss_irq_o <= ref_lost_i & ctrl_reg.ref_loss_irq_en;
		end
	end

	// --------------------------------------------------------------
	// source selection and postscaler
	// --------------------------------------------------------------
	// the master clock is whichever source the prescaler select picks
	assign prescaler_tick = ctrl_reg.prescaler_src_sel ? ext_ref_tick_i
	                                                   : relax_osc_tick_i;

	always_comb begin
		if (!force_master && ctrl_reg.sysclk_src_sel == csc_pkg::SRC_PLL) begin
			source_tick = pll_out_tick_i;
			src_state   = csc_pkg::SRC_PLL;
		end else begin
			source_tick = prescaler_tick;
			src_state   = csc_pkg::SRC_MASTER;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sysclk_src_state_o <= csc_pkg::SRC_MASTER;
		end else begin
			sysclk_src_state_o <= src_state;
		end
	end

	csc_postscaler #(
		.CNT_W (8)
	) u_postscaler (
		.clk_sys_i  (clk_sys_i),
		.nrst_i     (nrst_i),
		.tick_i     (source_tick),
		.div_code_i (divby_reg.postscaler_divide),
		.pulse_o    (double_rate_sys_clock_o)
	);

endmodule

// ---- csc_pkg.sv ----
// Purpose: constants and types shared by the clock synthesis control block
// Assumes: AXI4-Lite register access, 32-bit data, 16-bit registers in the low bits
// Notes:   register indices are word offsets; byte address is four times the index
//
// Operation
// - lock1 edge field: any/fall/rise/off interrupt select
// - lock0 edge field: same encoding for lock0
// - loss-of-reference interrupt raised only when enabled
// - lock detector enable bit drives detector on/off
// - power-down bit set turns PLL off
// - power-down change reaches PLL after four cycles
// - PLL powered down forces source select 01
// - prescaler select: 0 relaxation osc, 1 external
// - source select 01 master clock, 10 PLL
// - stop mode holds source select at 01
// - control bits 10 to 8 read zero
// - control bits 6, 5, 3 ignore writes
// - registers at word offsets 0 to 7, offset 3 reserved
// - after reset clock comes from relaxation osc
// - postscaler divides any source up to 256
// - divide code 2**n, top bit 256, glitch-free
package csc_pkg;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [2:0] IDX_PLL_CONTROL  = 3'h0;
	localparam logic [2:0] IDX_DIVIDE_BY    = 3'h1;
	localparam logic [2:0] IDX_SYNTH_STATUS = 3'h2;
	localparam logic [2:0] IDX_RESERVED     = 3'h3;
	localparam logic [2:0] IDX_OSC_CONTROL  = 3'h4;
	localparam logic [2:0] IDX_CHECK_REF    = 3'h5;
	localparam logic [2:0] IDX_CHECK_TARGET = 3'h6;
	localparam logic [2:0] IDX_WRITE_PROT   = 3'h7;
	localparam int         ADDR_W           = 5;
	localparam int         IDX_LSB          = 2;

	// ------------------------------------------------------------------
	// field encodings
	// ------------------------------------------------------------------
	localparam logic [1:0] SRC_MASTER   = 2'h1;
	localparam logic [1:0] SRC_PLL      = 2'h2;
	localparam logic [1:0] EDGE_OFF     = 2'h0;
	localparam logic [1:0] AXI_OKAY     = 2'h0;
	localparam logic [1:0] AXI_SLVERR   = 2'h2;
	localparam int         PD_DELAY     = 4;
	localparam int         COD_W        = 4;
	localparam int         LORTP_W      = 4;

	// ------------------------------------------------------------------
	// control register layout, bits 15 down to 0
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] lock1_irq_edge_sel;
		logic [1:0] lock0_irq_edge_sel;
		logic       ref_loss_irq_en;
		logic [2:0] rsvd_10_8;
		logic       lock_detector_en;
		logic [1:0] rsvd_6_5;
		logic       pll_power_down;
		logic       rsvd_3;
		logic       prescaler_src_sel;
		logic [1:0] sysclk_src_sel;
	} csc_ctrl_type;

	typedef struct packed {
		logic [LORTP_W-1:0] loss_trip;
		logic [COD_W-1:0]   postscaler_divide;
	} csc_divby_type;

	// status layout: [5] lock1, [4] lock0, [3] pll off, [2] ref lost, [1:0] source state
	localparam int ST_LOCK1  = 5;
	localparam int ST_LOCK0  = 4;
	localparam int ST_PLLOFF = 3;
	localparam int ST_LOSS   = 2;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] CTRL_RESET  = 16'h0011;
	localparam logic [15:0] CTRL_WMASK  = 16'hF897;
	localparam logic [15:0] DIVBY_RESET = 16'h0000;
	localparam logic [15:0] OTHER_RESET = 16'h0000;

endpackage

// ---- csc_edge_detect.sv ----
// Purpose: lock flag edge detector with selectable edge mode
// Assumes: flag is synchronous to the clock
// Notes:   one-cycle interrupt pulse per qualified edge
`timescale 1ns/10ps
module csc_edge_detect (
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       nrst_i,
	// flag and mode
	input  wire logic       flag_i,
	input  wire logic [1:0] mode_i,
	// event
	output logic            irq_o
);
	logic prev_reg;
	logic rise;
	logic fall;

	// --------------------------------------------------------------
	// compare with the previous sample
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= flag_i;
		end
	end

	assign rise = flag_i & ~prev_reg;
	assign fall = ~flag_i & prev_reg;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= (mode_i[0] & rise) | (mode_i[1] & fall);
		end
	end
endmodule

// ---- csc_postscaler.sv ----
// Purpose: power-of-two postscaler on a source tick stream
// Assumes: ticks are one-cycle pulses synchronous to the clock
// Notes:   a new divisor takes effect only at the end of a period
`timescale 1ns/10ps
module csc_postscaler #(
	parameter int CNT_W = 8
) (
	// clock and reset
	input  wire logic                  clk_sys_i,
	input  wire logic                  nrst_i,
	// source and divisor
	input  wire logic                  tick_i,
	input  wire logic [csc_pkg::COD_W-1:0] div_code_i,
	// divided output
	output logic                       pulse_o
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] term_reg;
	logic [CNT_W-1:0] term_next;

	initial begin
		if (CNT_W < 8) $error("postscaler counter too narrow for divide by 256");
	end

	// code 1xxx divides by 256, else by 2**code
	always_comb begin
		if (div_code_i[csc_pkg::COD_W-1]) begin
			term_next = {CNT_W{1'b1}} >> (CNT_W - 8);
		end else begin
			term_next = CNT_W'((9'h001 << div_code_i[2:0]) - 9'h001);
		end
	end

	// --------------------------------------------------------------
	// counter; divisor sampled at wrap so no short period appears
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_reg  <= '0;
			term_reg <= '0;
			pulse_o  <= 1'b0;
		end else begin
			pulse_o <= 1'b0;
			if (tick_i) begin
				if (cnt_reg >= term_reg) begin
					cnt_reg  <= '0;
					term_reg <= term_next;
					pulse_o  <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
		end
	end
endmodule

// ---- csc_synth_properties.sv ----
// Purpose: port-level properties of the clock synthesis control block
// Assumes: one clock domain, reset active low
// Notes:   bound to the top module at the foot of this file
`timescale 1ns/10ps
module csc_synth_properties #(
	parameter int PD_DELAY = 4
) (
	// clock and reset
	input wire logic        clk_sys_i,
	input wire logic        nrst_i,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic [1:0]  s_axi_rresp,
	// sources and status
	input wire logic        relax_osc_tick_i,
	input wire logic        ext_ref_tick_i,
	input wire logic        pll_out_tick_i,
	input wire logic        stop_mode_i,
	input wire logic        lock0_flag_i,
	input wire logic        lock1_flag_i,
	input wire logic        ref_lost_i,
	// outputs
	input wire logic        pll_power_down_o,
	input wire logic        lock0_irq_o,
	input wire logic        lock1_irq_o,
	input wire logic        ref_loss_irq_o,
	input wire logic        double_rate_sys_clock_o,
	input wire logic [1:0]  sysclk_src_state_o
);
	logic wr_hs;
	assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	// ------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------
	// edge pulse may lag the flag by one or two cycles
	property p_lock1_edge;
		lock1_irq_o |-> $past(lock1_flag_i) != $past(lock1_flag_i, 2)
			|| $past(lock1_flag_i, 2) != $past(lock1_flag_i, 3);
	endproperty
	a_lock1_edge: assert property (p_lock1_edge) else $error("lock1 pulse without edge");
	property p_lock0_edge;
		lock0_irq_o |-> $past(lock0_flag_i) != $past(lock0_flag_i, 2)
			|| $past(lock0_flag_i, 2) != $past(lock0_flag_i, 3);
	endproperty
	a_lock0_edge: assert property (p_lock0_edge) else $error("lock0 pulse without edge");
	property p_loss_cause;
		ref_loss_irq_o |-> $past(ref_lost_i);
	endproperty
	a_loss_cause: assert property (p_loss_cause) else $error("loss irq without loss");
	property p_loss_off;
		!ref_lost_i |=> !ref_loss_irq_o;
	endproperty
	a_loss_off: assert property (p_loss_off) else $error("loss irq stays up");
	property p_pd_delay;
		$changed(pll_power_down_o) |-> $past(wr_hs, PD_DELAY) || $past(wr_hs, PD_DELAY + 1);
	endproperty
	a_pd_delay: assert property (p_pd_delay) else $error("power down not delayed");
	property p_pd_forces;
		$rose(pll_power_down_o) |-> sysclk_src_state_o == csc_pkg::SRC_MASTER;
	endproperty
	a_pd_forces: assert property (p_pd_forces) else $error("pll off but not master");
	property p_src_legal;
		sysclk_src_state_o == csc_pkg::SRC_MASTER || sysclk_src_state_o == csc_pkg::SRC_PLL;
	endproperty
	a_src_legal: assert property (p_src_legal) else $error("reserved source state");
	property p_stop_master;
		stop_mode_i [*3] |-> sysclk_src_state_o == csc_pkg::SRC_MASTER;
	endproperty
	a_stop_master: assert property (p_stop_master) else $error("stop without master");
	property p_tick_cause;
		double_rate_sys_clock_o |-> $past(relax_osc_tick_i || ext_ref_tick_i || pll_out_tick_i);
	endproperty
	a_tick_cause: assert property (p_tick_cause) else $error("output pulse without tick");
	property p_unmapped;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h0000000C
			|=> s_axi_rresp == csc_pkg::AXI_SLVERR;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("reserved slot answered okay");
endmodule

bind csc_clock_synth_unit csc_synth_properties #(.PD_DELAY(PD_DELAY)) u_props (
	.clk_sys_i, .nrst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rresp, .relax_osc_tick_i,
	.ext_ref_tick_i, .pll_out_tick_i, .stop_mode_i, .lock0_flag_i, .lock1_flag_i,
	.ref_lost_i, .pll_power_down_o, .lock0_irq_o, .lock1_irq_o, .ref_loss_irq_o,
	.double_rate_sys_clock_o, .sysclk_src_state_o
);

// ---- csc_siu_model.sv ----
// Purpose: consumer of the double-rate clock tick train
// Assumes: ticks are one-cycle pulses
// Notes:   reports the spacing of the last two ticks and a running count
`timescale 1ns/10ps
module csc_siu_model (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic nrst_i,
	// clock in, measurements out
	input  wire logic clk_tick_i,
	output int        gap_o,
	output int        pulses_o
);
	int cnt;
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt <= 0;
			gap_o <= 0;
			pulses_o <= 0;
		end else if (clk_tick_i === 1'h1) begin
			gap_o <= cnt + 1;
			cnt <= 0;
			pulses_o <= pulses_o + 1;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// ---- csc_clock_synth_unit_tb.sv ----
// Purpose: register and clock behaviour test of the clock synthesis control block
// Assumes: relaxation ticks every cycle, external every 2nd, pll every 4th
// Notes:   waits are bounded; a spent bound ends the run
`timescale 1ns/10ps
module csc_clock_synth_unit_tb;
	logic clk_sys_i = 1'h0, nrst_i = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ext_on = 1'h0;
	logic relax_osc_tick_i = 1'h1, ext_ref_tick_i = 1'h0, pll_out_tick_i = 1'h0;
	logic stop_mode_i = 1'h0, lock0_flag_i = 1'h0, lock1_flag_i = 1'h0, ref_lost_i = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, d;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] cyc = 2'h0, r;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic pll_power_down_o, lock_detector_en_o, lock0_irq_o, lock1_irq_o, ref_loss_irq_o;
	logic double_rate_sys_clock_o;
	logic [15:0] osc_control_o;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp, s_axi_bresp, sysclk_src_state_o;
	int n_fail = 0, checked = 0, c0 = 0, c1 = 0, gap, pulses;
	int ex[6] = '{256, 256, 128, 8, 2, 1};
	logic [3:0] cd[6] = '{4'hF, 4'h8, 4'h7, 4'h3, 4'h1, 4'h0};
	// ------------------------------------------------------------------
	// design, consumer model, clock and sources
	// ------------------------------------------------------------------
	csc_clock_synth_unit #(.PD_DELAY(4)) dut (.clk_sys_i, .nrst_i, .s_axi_awvalid,
		.s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .relax_osc_tick_i, .ext_ref_tick_i,
		.pll_out_tick_i, .stop_mode_i, .lock0_flag_i, .lock1_flag_i, .ref_lost_i,
		.pll_power_down_o, .lock_detector_en_o, .osc_control_o, .lock0_irq_o,
		.lock1_irq_o, .ref_loss_irq_o, .double_rate_sys_clock_o, .sysclk_src_state_o);
	csc_siu_model u_siu (.clk_sys_i, .nrst_i, .clk_tick_i(double_rate_sys_clock_o),
		.gap_o(gap), .pulses_o(pulses));
	always #2.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 2'h1;
		ext_ref_tick_i <= ext_on & cyc[0];
		pll_out_tick_i <= (cyc == 2'h3);
		if (lock0_irq_o === 1'h1) c0++;
		if (lock1_irq_o === 1'h1) c1++;
	end
	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic conclude();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic lim(input int n);
		if (n >= 3000) begin
			n_fail++;
			$display("[FAIL] %0t wait expired", $time);
			conclude();
		end
	endtask
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// readies are combinational: look at them mid-cycle, act on the next edge
	task automatic wr(input logic [31:0] a, input logic [15:0] v);
		int n = 0;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, v};
		s_axi_bready <= 1'h1;
		do begin @(negedge clk_sys_i); n++; end while (!(s_axi_awready && s_axi_wready) && n < 3000);
		@(posedge clk_sys_i);
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		do begin @(negedge clk_sys_i); n++; end while (s_axi_bvalid !== 1'h1 && n < 3000);
		@(posedge clk_sys_i);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
		lim(n);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n = 0;
		s_axi_arvalid <= 1'h1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'h1;
		do begin @(negedge clk_sys_i); n++; end while (s_axi_arready !== 1'h1 && n < 3000);
		@(posedge clk_sys_i);
		s_axi_arvalid <= 1'h0;
		do begin @(negedge clk_sys_i); n++; end while (s_axi_rvalid !== 1'h1 && n < 3000);
		@(posedge clk_sys_i);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
		lim(n);
	endtask
	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		rd(a, d, r);
		chk({r, d}, {csc_pkg::AXI_OKAY, e});
	endtask
	// a new divisor lands after the running period, so skip two ticks
	task automatic gm(input int e);
		int n = 0;
		int p = pulses;
		while (pulses < p + 3 && n < 3000) begin @(posedge clk_sys_i); n++; end
		lim(n);
		chk(gap, e);
	endtask
	// ------------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys_i);
		nrst_i <= 1'h1;
		@(posedge clk_sys_i);
		rc(32'h0, 32'h11);
		chk(pll_power_down_o, 1'h1);
		chk(sysclk_src_state_o, csc_pkg::SRC_MASTER);
		gm(1);
		for (int i = 4; i < 8; i++) begin
			wr(i * 4, 16'hA5C3);
			rc(i * 4, 32'hA5C3);
		end
		chk(osc_control_o, 32'hA5C3);
		wr(32'h4, 16'hFFFF);
		rc(32'h4, 32'hFF00);
		for (int i = 0; i < 6; i++) begin
			wr(32'h4, {4'h0, cd[i], 8'h00});
			gm(ex[i]);
		end
		wr(32'hC, 16'hFFFF);
		chk(r, csc_pkg::AXI_SLVERR);
		rd(32'hC, d, r);
		chk({r, d}, {csc_pkg::AXI_SLVERR, 32'h0});
		wr(32'h0, 16'hFFFF);
		chk(r, csc_pkg::AXI_OKAY);
		rc(32'h0, 32'hF895);
		ref_lost_i <= 1'h1;
		repeat (3) @(posedge clk_sys_i);
		chk(ref_loss_irq_o, 1'h1);
		rc(32'h8, 32'h0D);
		wr(32'h0, 16'h0011);
		repeat (3) @(posedge clk_sys_i);
		chk(ref_loss_irq_o, 1'h0);
		ref_lost_i <= 1'h0;
		for (int m = 0; m < 4; m++) begin
			wr(32'h0, {m[1:0], m[1:0], 12'h011});
			c0 = 0;
			c1 = 0;
			lock0_flag_i <= 1'h1;
			lock1_flag_i <= 1'h1;
			repeat (4) @(posedge clk_sys_i);
			lock0_flag_i <= 1'h0;
			lock1_flag_i <= 1'h0;
			repeat (4) @(posedge clk_sys_i);
			chk(c1, (m == 3) ? 2 : (m != 0));
			chk(c0, (m == 3) ? 2 : (m != 0));
		end
		wr(32'h0, 16'h0082);
		repeat (2) @(posedge clk_sys_i);
		chk(pll_power_down_o, 1'h1);
		repeat (2) @(posedge clk_sys_i);
		chk(pll_power_down_o, 1'h0);
		chk(lock_detector_en_o, 1'h1);
		rc(32'h0, 32'h82);
		chk(sysclk_src_state_o, csc_pkg::SRC_PLL);
		gm(4);
		stop_mode_i <= 1'h1;
		repeat (3) @(posedge clk_sys_i);
		chk(sysclk_src_state_o, csc_pkg::SRC_MASTER);
		rc(32'h0, 32'h81);
		gm(1);
		stop_mode_i <= 1'h0;
		ext_on <= 1'h1;
		wr(32'h0, 16'h0085);
		gm(2);
		wr(32'h0, 16'h0012);
		rc(32'h0, 32'h11);
		gm(1);
		chk(lock_detector_en_o, 1'h0);
		chk(pll_power_down_o, 1'h1);
		conclude();
	end
endmodule
